// file: core/fbl_flash_dev.sv
// Flash command end: write enable latch and per-block lock handling
// Overview of operation
// - Write-enable opcode sets latch at frame end
// - Program, erase need latch set; status write needs latch or arm
// - Write-disable opcode clears latch at frame end
// - Volatile enable arms next status write only
// - Host sends volatile enable before volatile write
// - One-byte commands, MSB first, eight clocks
// - Frame ending mid-byte is aborted, no change
// - Host clocks whole command before raising select
// - Lock: opcode, 24 address bits, sets bit
// - Unlock: opcode, 24 address bits, clears bit
// - Lock or unlock then clears the latch
// - Host sets latch before each lock command
// - Block locks apply only when select set
// - All lock bits are one after reset
// - Locked block refuses program and erase
// - Lock granule is 4KB, low bits ignored
`timescale 1ns/1ps
module fbl_flash_dev #(
  parameter int NUM_BLOCKS = fbl_pkg::NUM_BLOCKS
) (
  // System clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  resetn_i,
  // Serial link, clocked by its own serial clock
  fbl_spi_if.dev                     spi,
  // Protection configuration
  input  wire logic                  block_protect_select_i,
  input  wire logic                  protect_range_hit_i,
  // State
  output      logic                  write_enable_latch_o,
  output      logic                  volatile_armed_o,
  output      logic [NUM_BLOCKS-1:0] lock_bits_o,
  // Executed command report
  output      logic                  cmd_valid_o,
  output      logic [7:0]            cmd_opcode_o,
  output      logic [23:0]           cmd_addr_o,
  output      logic                  cmd_accept_o,
  output      logic                  cmd_volatile_o,
  output      logic                  frame_abort_o
);
  localparam int BW = $clog2(NUM_BLOCKS);

  // ****************************************
  // Parameter check
  // ****************************************
  if (NUM_BLOCKS < 2 ||
      NUM_BLOCKS > (1 << (fbl_pkg::ADDR_BITS - fbl_pkg::BLOCK_SHIFT)) ||
      (1 << BW) != NUM_BLOCKS) begin : g_bad_blocks
    $error("NUM_BLOCKS must be a power of two fitting the address");
  end

  // ****************************************
  // Decoders
  // ****************************************
  // block from address
  function automatic logic [BW-1:0] blk_of(input logic [23:0] a);
    blk_of = a[fbl_pkg::BLOCK_SHIFT +: BW];
  endfunction

  function automatic logic is_addr_pe(input logic [7:0] op);
    is_addr_pe = op == fbl_pkg::OP_PP     || op == fbl_pkg::OP_PP_DUAL ||
                 op == fbl_pkg::OP_PP_QUAD || op == fbl_pkg::OP_SEQ_A  ||
                 op == fbl_pkg::OP_SEQ_B   || op == fbl_pkg::OP_ER_4K  ||
                 op == fbl_pkg::OP_ER_32K  || op == fbl_pkg::OP_ER_64K ||
                 op == fbl_pkg::OP_OTP_PP;
  endfunction

  function automatic logic is_chip_er(input logic [7:0] op);
    is_chip_er = op == fbl_pkg::OP_ER_CHIP || op == fbl_pkg::OP_ER_CHP2;
  endfunction

  function automatic logic is_sr_wr(input logic [7:0] op);
    is_sr_wr = op == fbl_pkg::OP_SR_WR1 || op == fbl_pkg::OP_SR_WR2 ||
               op == fbl_pkg::OP_SR_WR3 || op == fbl_pkg::OP_SR_WR4;
  endfunction

  // ****************************************
  // Link domain: bit and byte counting
  // ****************************************
  typedef struct packed {
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_cnt;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [22:0] sh;
  } fbl_link_t;

  fbl_link_t lnk;
  fbl_link_t next_lnk;
  logic      in_frame;

  // Marks the first edge of a frame; select high empties it at once,
  // so no edge before the frame is needed to restart the counters
  always_ff @(posedge spi.sclk or posedge spi.cs_n) begin
    if (spi.cs_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  always_comb begin
    next_lnk = lnk;
    if (!in_frame) begin
      next_lnk.bit_cnt  = 3'h0;
      next_lnk.byte_cnt = 3'h0;
    end
    next_lnk.sh = {next_lnk.sh[21:0], spi.si};
    if (next_lnk.bit_cnt == 3'h7) begin
      if (next_lnk.byte_cnt == 3'h0) begin
        next_lnk.op = {lnk.sh[6:0], spi.si};
      end
      if (next_lnk.byte_cnt == 3'h3) begin
        next_lnk.addr = {lnk.sh, spi.si};
      end
      if (next_lnk.byte_cnt != 3'h7) begin
        next_lnk.byte_cnt = next_lnk.byte_cnt + 3'h1;
      end
    end
    next_lnk.bit_cnt = next_lnk.bit_cnt + 3'h1;
  end

  // Quiet at reset: counters restart on every frame's first edge
  always_ff @(posedge spi.sclk) begin
    lnk <= next_lnk;
  end

  // ****************************************
  // System domain: command execution
  // ****************************************
  typedef struct packed {
    logic                  cs_q;
    logic                  wlat;
    logic                  varm;
    logic [NUM_BLOCKS-1:0] locks;
    logic                  ex_v;
    logic [7:0]            ex_op;
    logic [23:0]           ex_addr;
    logic                  ex_ok;
    logic                  ex_vol;
    logic                  ab;
  } fbl_dev_t;

  fbl_dev_t s;
  fbl_dev_t next_s;
  logic     cs_n_s;

  fbl_sync #(
    .W   (1),
    .RST (1'b1)
  ) u_cs_sync (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .d_i       (spi.cs_n),
    .q_o       (cs_n_s)
  );

  // Link registers are read only after select has risen; the serial
  // clock is then still, so they are stable for the whole gap
  always_comb begin
    logic          fin;
    logic          one_b;
    logic          adr_b;
    logic          prot;
    logic [BW-1:0] blk;
    fin   = cs_n_s && !s.cs_q;
    one_b = lnk.byte_cnt == fbl_pkg::BYTES_OP;
    adr_b = lnk.byte_cnt >= fbl_pkg::BYTES_ADDR;
    blk   = blk_of(lnk.addr);
    prot  = 1'b0;
    next_s      = s;
    next_s.cs_q = cs_n_s;
    next_s.ex_v = 1'b0;
    next_s.ab   = 1'b0;
    if (fin) begin
      if (lnk.bit_cnt != 3'h0 || lnk.byte_cnt == 3'h0) begin
        next_s.ab = 1'b1;
      end else if (lnk.op == fbl_pkg::OP_WREN) begin
        if (one_b) next_s.wlat = 1'b1;
      end else if (lnk.op == fbl_pkg::OP_WRDI) begin
        if (one_b) next_s.wlat = 1'b0;
      end else if (lnk.op == fbl_pkg::OP_VWREN) begin
        if (one_b) next_s.varm = 1'b1;
      end else if (lnk.op == fbl_pkg::OP_LOCK ||
                   lnk.op == fbl_pkg::OP_UNLOCK) begin
        if (lnk.byte_cnt == fbl_pkg::BYTES_ADDR && s.wlat) begin
          next_s.locks[blk] = lnk.op == fbl_pkg::OP_LOCK;
          next_s.wlat       = 1'b0;
        end
      end else if ((is_addr_pe(lnk.op) && adr_b) ||
                   (is_chip_er(lnk.op) && one_b)) begin
        if (block_protect_select_i) begin
          prot = is_chip_er(lnk.op) ? |s.locks : s.locks[blk];
        end else begin
          prot = protect_range_hit_i;
        end
        next_s.ex_v    = 1'b1;
        next_s.ex_op   = lnk.op;
        next_s.ex_addr = is_chip_er(lnk.op) ? 24'h0 : lnk.addr;
        next_s.ex_vol  = 1'b0;
        next_s.ex_ok   = s.wlat && !prot;
        if (next_s.ex_ok) next_s.wlat = 1'b0;
      end else if (is_sr_wr(lnk.op) && !one_b) begin
        // one status write consumes the arm
        next_s.ex_v    = 1'b1;
        next_s.ex_op   = lnk.op;
        next_s.ex_addr = 24'h0;
        next_s.ex_vol  = s.varm;
        next_s.ex_ok   = s.wlat || s.varm;
        next_s.varm    = 1'b0;
        if (!s.varm && s.wlat) next_s.wlat = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s.cs_q    <= 1'b1;
      s.wlat    <= fbl_pkg::LATCH_RST;
      s.varm    <= fbl_pkg::VARM_RST;
      s.locks   <= {NUM_BLOCKS{fbl_pkg::LOCK_RST}};
      s.ex_v    <= 1'b0;
      s.ex_op   <= 8'h00;
      s.ex_addr <= 24'h000000;
      s.ex_ok   <= 1'b0;
      s.ex_vol  <= 1'b0;
      s.ab      <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign write_enable_latch_o = s.wlat;
  assign volatile_armed_o     = s.varm;
  assign lock_bits_o          = s.locks;
  assign cmd_valid_o          = s.ex_v;
  assign cmd_opcode_o         = s.ex_op;
  assign cmd_addr_o           = s.ex_addr;
  assign cmd_accept_o         = s.ex_ok;
  assign cmd_volatile_o       = s.ex_vol;
  assign frame_abort_o        = s.ab;
endmodule

// file: core/fbl_pkg.sv
// Shared constants for the serial flash write-enable and block-lock ends
package fbl_pkg;

  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_VWREN   = 8'h50;
  localparam logic [7:0] OP_LOCK    = 8'h36;
  localparam logic [7:0] OP_UNLOCK  = 8'h39;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_PP_DUAL = 8'ha2;
  localparam logic [7:0] OP_PP_QUAD = 8'h32;
  localparam logic [7:0] OP_SEQ_A   = 8'haf;
  localparam logic [7:0] OP_SEQ_B   = 8'had;
  localparam logic [7:0] OP_ER_4K   = 8'h20;
  localparam logic [7:0] OP_ER_32K  = 8'h52;
  localparam logic [7:0] OP_ER_64K  = 8'hd8;
  localparam logic [7:0] OP_ER_CHIP = 8'h60;
  localparam logic [7:0] OP_ER_CHP2 = 8'hc7;
  localparam logic [7:0] OP_OTP_PP  = 8'h9b;
  localparam logic [7:0] OP_SR_WR1  = 8'h01;
  localparam logic [7:0] OP_SR_WR2  = 8'h31;
  localparam logic [7:0] OP_SR_WR3  = 8'h11;
  localparam logic [7:0] OP_SR_WR4  = 8'h71;

  // ****************************************
  // Frame layout
  // ****************************************
  localparam int          ADDR_BITS    = 24;
  localparam logic [2:0]  BYTES_OP     = 3'h1;
  localparam logic [2:0]  BYTES_ADDR   = 3'h4;
  localparam int          BLOCK_SHIFT  = 12;
  localparam int          NUM_BLOCKS   = 128;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic        LOCK_RST     = 1'b1;
  localparam logic        LATCH_RST    = 1'b0;
  localparam logic        VARM_RST     = 1'b0;

  // ****************************************
  // Host register map (byte addresses)
  // ****************************************
  localparam logic [3:0]  REG_CMD      = 4'h0;
  localparam logic [3:0]  REG_ADDR     = 4'h4;
  localparam logic [3:0]  REG_STAT     = 4'h8;
  localparam int          CMD_ADDR_BIT = 8;
  localparam int          STAT_BUSY    = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS        = 20;
  localparam int SCLK_HALF_NS  = 40;
  localparam int CS_GAP_NS     = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_GAP_CYC    = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;

endpackage

// file: core/fbl_spi_if.sv
// Serial link between the flash command logic and its host controller
`timescale 1ns/1ps
interface fbl_spi_if;
  logic cs_n;
  logic sclk;
  logic si;

  modport host (output cs_n, output sclk, output si);
  modport dev  (input cs_n, input sclk, input si);
endinterface

// file: core/fbl_sync.sv
// Two-stage level synchroniser
`timescale 1ns/1ps
module fbl_sync #(
  parameter int   W   = 1,
  parameter logic RST = 1'b0
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         resetn_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output      logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      meta <= {W{RST}};
      q_o  <= {W{RST}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// file: core/fbl_flash_host.sv
// Host controller end: sends one-byte and addressed flash commands
`timescale 1ns/1ps
module fbl_flash_host #(
  parameter int HALF_CYC = fbl_pkg::SCLK_HALF_CYC,
  parameter int GAP_CYC  = fbl_pkg::CS_GAP_CYC
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output      logic [31:0] avs_readdata,
  output      logic        avs_waitrequest,
  // Serial link; this end makes the serial clock
  fbl_spi_if.host          spi
);
  if (HALF_CYC < 1 || HALF_CYC > 255 || GAP_CYC < 4 || GAP_CYC > 255)
  begin : g_bad_timing
    $error("HALF_CYC must be 1..255 and GAP_CYC 4..255");
  end

  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
  localparam logic [7:0] GAP_M1  = 8'(GAP_CYC - 1);

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_SETUP = 2'b01,
    H_SHIFT = 2'b11,
    H_GAP   = 2'b10
  } fbl_hst_t;

  typedef struct packed {
    fbl_hst_t    st;
    logic [7:0]  div;
    logic [5:0]  bits;
    logic [31:0] sh;
    logic [23:0] addr;
    logic        cs_n;
    logic        sclk;
    logic        si;
    logic        rd_ack;
    logic [31:0] rdata;
  } fbl_host_t;

  fbl_host_t h;
  fbl_host_t next_h;
  logic      cmd_wr;
  logic      busy;

  // ****************************************
  // Register access
  // ****************************************
  assign busy   = h.st != H_IDLE;
  assign cmd_wr = avs_write && avs_address == fbl_pkg::REG_CMD;
  // A new command waits until the previous frame and its gap are done
  assign avs_waitrequest = (cmd_wr && busy) || (avs_read && !h.rd_ack);

  always_comb begin
    logic tick;
    tick          = h.div == HALF_M1;
    next_h        = h;
    next_h.rd_ack = avs_read && !h.rd_ack;
    if (avs_read && !h.rd_ack) begin
      unique case (avs_address)
        fbl_pkg::REG_ADDR: next_h.rdata = {8'h00, h.addr};
        fbl_pkg::REG_STAT: next_h.rdata = {31'h0, busy};
        default:           next_h.rdata = 32'h0;
      endcase
    end
    if (avs_write && avs_address == fbl_pkg::REG_ADDR) begin
      next_h.addr = avs_writedata[23:0];
    end
    next_h.div = tick ? 8'h00 : h.div + 8'h01;
    unique case (h.st)
      H_IDLE: begin
        next_h.div = 8'h00;
        if (cmd_wr) begin
          next_h.sh   = {avs_writedata[7:0], h.addr};
          next_h.bits = avs_writedata[fbl_pkg::CMD_ADDR_BIT] ? 6'd32 : 6'd8;
          next_h.cs_n = 1'b0;
          next_h.si   = avs_writedata[7];
          next_h.st   = H_SETUP;
        end
      end
      H_SETUP: begin
        if (tick) begin
          next_h.sclk = 1'b1;
          next_h.st   = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (tick && h.sclk) begin
          next_h.sclk = 1'b0;
          next_h.sh   = {h.sh[30:0], 1'b0};
          next_h.si   = h.sh[30];
          next_h.bits = h.bits - 6'd1;
          // select rises only after the last bit
          if (h.bits == 6'd1) begin
            next_h.cs_n = 1'b1;
            next_h.si   = 1'b0;
            next_h.st   = H_GAP;
          end
        end else if (tick) begin
          next_h.sclk = 1'b1;
        end
      end
      H_GAP: begin
        // Free count here: the half-period wrap would never reach the gap
        next_h.div = h.div + 8'h01;
        if (h.div == GAP_M1) begin
          next_h.st = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      h.st     <= H_IDLE;
      h.div    <= 8'h00;
      h.bits   <= 6'd0;
      h.sh     <= 32'h0;
      h.addr   <= 24'h0;
      h.cs_n   <= 1'b1;
      h.sclk   <= 1'b0;
      h.si     <= 1'b0;
      h.rd_ack <= 1'b0;
      h.rdata  <= 32'h0;
    end else begin
      h <= next_h;
    end
  end

  assign avs_readdata = h.rdata;
  assign spi.cs_n     = h.cs_n;
  assign spi.sclk     = h.sclk;
  assign spi.si       = h.si;
endmodule

// file: sim/fbl_link_chk.sv
// Assertions on the serial link and the command end's state
`timescale 1ns/1ps
module fbl_link_chk #(
  parameter int NUM_BLOCKS = 128
) (
  // Clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  resetn_i,
  // Link
  input wire logic                  cs_n,
  input wire logic                  sclk,
  input wire logic                  si,
  // Device state and report
  input wire logic                  write_enable_latch_o,
  input wire logic                  volatile_armed_o,
  input wire logic [NUM_BLOCKS-1:0] lock_bits_o,
  input wire logic                  cmd_valid_o,
  input wire logic                  cmd_accept_o,
  input wire logic                  cmd_volatile_o
);
  logic [5:0] bit_cnt;
  logic       sclk_q;

  // Serial clock is a flop output, so its rises are countable here
  always_ff @(posedge clk_sys_i) begin
    sclk_q <= sclk;
    if (cs_n)
      bit_cnt <= 6'h00;
    else if (sclk && !sclk_q)
      bit_cnt <= bit_cnt + 6'h01;
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_end;
    $rose(cs_n);
  endsequence
  sequence s_gap;
    cs_n [*4];
  endsequence

  chk_frame_gap: assert property (s_end |=> s_gap)
    else $error("select gap too short");
  chk_frame_len: assert property (s_end |->
    (bit_cnt == 6'h08 || bit_cnt == 6'h20))
    else $error("frame length not 8 or 32 bits");
  chk_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock not idle low");
  chk_si_hold: assert property ($changed(si) |-> !sclk)
    else $error("data moved while clock high");
  chk_latch_hold: assert property ($changed(write_enable_latch_o) |->
    cs_n && $past(cs_n, 2))
    else $error("latch moved inside a frame");
  chk_lock_latch: assert property ($changed(lock_bits_o) |->
    cs_n && $past(write_enable_latch_o) && !write_enable_latch_o)
    else $error("lock change without latch use");
  chk_gated_cmd: assert property (cmd_valid_o && cmd_accept_o &&
    !cmd_volatile_o |-> $past(write_enable_latch_o))
    else $error("command ran without latch");
  chk_vol_arm: assert property (cmd_valid_o && cmd_volatile_o |->
    $past(volatile_armed_o) && !volatile_armed_o)
    else $error("arm not consumed once");
  chk_valid_pulse: assert property (cmd_valid_o |=> !cmd_valid_o [*8])
    else $error("report pulse too long");
  chk_lock_reset: assert property ($rose(resetn_i) |->
    &lock_bits_o && !write_enable_latch_o)
    else $error("bad state after reset");
endmodule

// file: sim/spi_flash_write_enable_block_lock_tb_top.sv
// Testbench joining host and flash ends, plus a rule-breaking link
`timescale 1ns/1ps
module spi_flash_write_enable_block_lock_tb_top;
  localparam int NB = fbl_pkg::NUM_BLOCKS;
  logic          clk_sys_i, resetn_i, clk_link, sclk_en, sel, hit;
  logic [3:0]    avs_address;
  logic          avs_read, avs_write, avs_waitrequest;
  logic [31:0]   avs_writedata, avs_readdata, shr;
  logic          latch, varm, cv, acc, vol, latch_b, ab_b, lacc, lvol;
  logic [23:0]   cad, ladr;
  logic [NB-1:0] locks, locks_b, exp;
  logic [7:0]    cop, lop;
  int            fails, num_checks, ncmd, nab, nbits;
  logic [7:0]    ops [13] = '{8'h02, 8'ha2, 8'h32, 8'haf, 8'had, 8'h20,
    8'h52, 8'hd8, 8'h60, 8'hc7, 8'h9b, 8'h01, 8'h31};

  fbl_spi_if link ();
  fbl_spi_if bad ();
  assign bad.sclk = clk_link & sclk_en;

  fbl_flash_host fbl_flash_host_inst (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .spi(link));
  fbl_flash_dev #(.NUM_BLOCKS(NB)) fbl_flash_dev_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .spi(link),
    .block_protect_select_i(sel), .protect_range_hit_i(hit),
    .write_enable_latch_o(latch), .volatile_armed_o(varm),
    .lock_bits_o(locks), .cmd_valid_o(cv), .cmd_opcode_o(cop),
    .cmd_addr_o(cad), .cmd_accept_o(acc), .cmd_volatile_o(vol),
    .frame_abort_o());
  fbl_flash_dev #(.NUM_BLOCKS(NB)) fbl_flash_dev_inst_b (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .spi(bad),
    .block_protect_select_i(sel), .protect_range_hit_i(hit),
    .write_enable_latch_o(latch_b), .volatile_armed_o(),
    .lock_bits_o(locks_b), .cmd_valid_o(), .cmd_opcode_o(),
    .cmd_addr_o(), .cmd_accept_o(), .cmd_volatile_o(),
    .frame_abort_o(ab_b));
  fbl_link_chk #(.NUM_BLOCKS(NB)) fbl_link_chk_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cs_n(link.cs_n),
    .sclk(link.sclk), .si(link.si), .write_enable_latch_o(latch),
    .volatile_armed_o(varm), .lock_bits_o(locks), .cmd_valid_o(cv),
    .cmd_accept_o(acc), .cmd_volatile_o(vol));

  // ****************************************
  // Clocks, monitors, bus tasks
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    clk_link = 1'b0;
    #3.3;
    forever #7.5 clk_link = ~clk_link;
  end
  always @(posedge clk_sys_i) begin
    if (cv === 1'b1) begin
      ncmd++;
      lop = cop;
      ladr = cad;
      lacc = acc;
      lvol = vol;
    end
    if (ab_b === 1'b1)
      nab++;
  end
  always @(posedge link.sclk) begin
    if (!link.cs_n) begin
      shr = {shr[30:0], link.si};
      nbits++;
    end
  end

  task check(input logic [191:0] seen, input logic [191:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t saw %0h want %0h", $time, seen, want);
    end
  endtask
  task av_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask
  task av_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task send(input logic [7:0] op, input logic wa, input logic [23:0] a);
    logic [31:0] st;
    nbits = 0;
    if (wa)
      av_wr(fbl_pkg::REG_ADDR, {8'h00, a});
    av_wr(fbl_pkg::REG_CMD, {23'h000000, wa, op});
    st = 32'h1;
    while (st[fbl_pkg::STAT_BUSY] !== 1'b0)
      av_rd(fbl_pkg::REG_STAT, st);
  endtask
  // Bench makes this clock, and only inside frames
  task bad_frame(input logic [31:0] bits, input int n);
    @(negedge clk_link) bad.cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_link);
      bad.si <= bits[31-i];
      sclk_en <= 1'b1;
    end
    @(negedge clk_link) sclk_en <= 1'b0;
    @(negedge clk_link) bad.cs_n <= 1'b1;
    bad.si <= ~bad.si;
    repeat (12) @(posedge clk_sys_i);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    logic [31:0] d;
    check({latch, varm, locks}, {2'h0, {NB{1'b1}}});
    av_wr(4'hc, 32'hffffffff);
    av_rd(4'hc, d);
    check(d, 32'h0);
    av_rd(fbl_pkg::REG_STAT, d);
    check(d[0], 1'b0);
  endtask
  task t_gate;
    logic wa;
    for (int i = 0; i < 13; i++) begin
      // Chip erase is a one-byte command; the others carry an address
      wa = !(ops[i] == fbl_pkg::OP_ER_CHIP || ops[i] == fbl_pkg::OP_ER_CHP2);
      send(fbl_pkg::OP_WREN, 1'b0, 24'h0);
      check({latch, nbits, shr[7:0]}, {1'b1, 32'd8, 8'h06});
      send(ops[i], wa, 24'h001000);
      check({lop, lacc, latch}, {ops[i], 2'b10});
      check(ladr, (wa && i < 11) ? 24'h001000 : 24'h000000);
      check(wa ? shr : {shr[7:0], 24'h001000}, {ops[i], 24'h001000});
      send(ops[i], wa, 24'h001000);
      check({lop, lacc, latch}, {ops[i], 2'b00});
      check(ncmd, 32'(2 * i + 2));
    end
    send(fbl_pkg::OP_WREN, 1'b0, 24'h0);
    send(fbl_pkg::OP_WRDI, 1'b0, 24'h0);
    check(latch, 1'b0);
    check(locks, exp);
  endtask
  task t_vol;
    send(fbl_pkg::OP_VWREN, 1'b0, 24'h0);
    check({latch, varm}, 2'b01);
    send(fbl_pkg::OP_SR_WR1, 1'b1, 24'h0000a5);
    check({lacc, lvol, varm}, 3'b110);
    send(fbl_pkg::OP_SR_WR1, 1'b1, 24'h0000a5);
    check(lacc, 1'b0);
  endtask
  task t_lock;
    sel <= 1'b1;
    send(fbl_pkg::OP_UNLOCK, 1'b1, 24'h005abc);
    check(locks, exp);
    send(fbl_pkg::OP_WREN, 1'b0, 24'h0);
    send(fbl_pkg::OP_UNLOCK, 1'b1, 24'h005abc);
    exp[5] = 1'b0;
    check({locks, latch}, {exp, 1'b0});
    check({nbits, shr}, {32'd32, 8'h39, 24'h005abc});
    send(fbl_pkg::OP_WREN, 1'b0, 24'h0);
    send(fbl_pkg::OP_PP, 1'b1, 24'h005010);
    check(lacc, 1'b1);
    send(fbl_pkg::OP_WREN, 1'b0, 24'h0);
    send(fbl_pkg::OP_PP, 1'b1, 24'h006000);
    check({lacc, latch}, 2'b01);
    sel <= 1'b0;
    send(fbl_pkg::OP_PP, 1'b1, 24'h006000);
    check(lacc, 1'b1);
    send(fbl_pkg::OP_WREN, 1'b0, 24'h0);
    hit <= 1'b1;
    send(fbl_pkg::OP_PP, 1'b1, 24'h005000);
    check(lacc, 1'b0);
    hit <= 1'b0;
    sel <= 1'b1;
    // fresh latch before every lock command
    send(fbl_pkg::OP_WREN, 1'b0, 24'h0);
    send(fbl_pkg::OP_LOCK, 1'b1, 24'h005fff);
    exp[5] = 1'b1;
    check({locks, latch}, {exp, 1'b0});
  endtask
  task t_abort;
    bad_frame({8'h06, 24'h0}, 7);
    check({nab, latch_b}, {32'd1, 1'b0});
    bad_frame({8'h06, 24'h0}, 8);
    check(latch_b, 1'b1);
    bad_frame({8'h39, 24'h003000}, 31);
    check({nab, latch_b, locks_b}, {32'd2, 1'b1, {NB{1'b1}}});
    bad_frame({8'h39, 24'h003000}, 32);
    check({latch_b, locks_b[3]}, 2'b00);
  endtask
  // Reset in mid-run must relock every block and drop the latch
  task t_rerst;
    send(fbl_pkg::OP_WREN, 1'b0, 24'h0);
    check(latch, 1'b1);
    resetn_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    check({latch, locks_b}, {1'b0, {NB{1'b1}}});
    check(locks, {NB{1'b1}});
  endtask

  initial begin
    {resetn_i, avs_read, avs_write, sel, hit, sclk_en} = 6'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    bad.cs_n = 1'b1;
    bad.si = 1'b0;
    exp = {NB{1'b1}};
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_gate();
    t_vol();
    t_lock();
    t_abort();
    t_rerst();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    fails++;
    complete_run();
  end
endmodule
